// *** shared/ops_pkg.sv ***
// Constants, register map and types for the operating point sequencer
`default_nettype none
package ops_pkg;
  // Table geometry
  localparam int NPTS = 254;
  localparam int PIDX_W = 8;
  localparam int NPV = 8;
  localparam int PV_W = 16;
  localparam int PVSEL_W = 3;
  localparam int DWELL_W = 31;
  localparam int LOOP_W = 16;
  // Millisecond timebase
  localparam int CLK_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int MSDIV_W = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MANUAL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_ERRPT = 8'h0c;
  localparam logic [7:0] OFS_LOOPLIM = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_LOOPDONE = 8'h18;
  localparam logic [7:0] OFS_ELAPSED = 8'h1c;
  localparam logic [7:0] OFS_COND = 8'h20;
  localparam logic [7:0] OFS_TIDX = 8'h24;
  localparam logic [7:0] OFS_TDWELL = 8'h28;
  localparam logic [7:0] OFS_TLO = 8'h2c;
  localparam logic [7:0] OFS_THI = 8'h30;
  // Control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_PAUSE = 1;
  localparam int CTRL_REWIND = 2;
  localparam int CTRL_MANUAL = 3;
  localparam int CTRL_TRIG = 4;
  localparam int CTRL_HOLD = 5;
  localparam int CTRL_MULTERR = 6;
  localparam int CTRL_IGNSYS = 7;
  localparam int CTRL_W = 8;
  // Status and condition register fields
  localparam int ST_MULT = 8;
  localparam int ST_NOMATCH = 9;
  localparam int ST_ENTRY = 10;
  localparam int ST_SYS = 11;
  localparam int ST_DONE = 12;
  localparam int COND_VALID = 8;
  // Table entry fields
  localparam int LO_INCL = 16;
  localparam int LO_BLANK = 17;
  localparam int LO_BAD = 18;
  localparam int LO_PVSEL = 20;
  localparam int HI_INCL = 16;
  localparam int DWELL_BAD = 31;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [PIDX_W-1:0] PIDX_RST = 8'h00;
  localparam logic [LOOP_W-1:0] LOOP_RST = 16'h0000;
  // Timed sequencing state
  typedef enum logic {SQ_RUN = 1'b0, SQ_DONE = 1'b1} ops_seq_t;
endpackage
`default_nettype wire

// *** verilog/ops_sequencer.sv ***
// Operating point sequencer with Avalon-MM register slave
`default_nettype none
// Overview of operation
// - Manual override forces the active point to the manual index.
// - Timed mode resumes from the present point after manual release.
// - Trigger mode returns to the evaluated point after manual release.
// - Only points below the point count take part.
// - Error point index is held and entered on error conditions.
// - Timed mode runs the loop limit times; zero means endless.
// - Completed loop count is readable in timed mode.
// - Timed mode steps points upward, each for its own dwell.
// - Trigger mode tests each point's variable against its range.
// - Elapsed dwell time in milliseconds is readable.
// - Active matching condition is readable in trigger mode.
// - Hold option keeps the present point when nothing matches.
// - Error option jumps to the error point on multiple match; no match without hold does too.
// - Multiple matches pick the highest matching index.
// - Multiple-match flag rises when several conditions match and the error option is set.
// - No-match flag rises when no condition matches.
// - Invalid dwell entry raises entry error and enters error point.
// - Invalid range entry raises entry error and enters error point.
// - System error flag shown; error point entered unless ignored.
// - Ignoring faults keeps normal execution running.
// - One indicator bit per point, only the active one set.
// - Each point selects its own process variable input.
// - At most 254 points are supported.
// - Enabled points drive the override; disabled keeps last applied.
// - Pause freezes timed execution at the present point.
// - Rewind returns timed execution to point zero.
module ops_sequencer #(
  parameter int MS_CYCLES = ops_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Process variables and fault pin
  input wire logic [ops_pkg::NPV*ops_pkg::PV_W-1:0] pv_i,
  input wire logic sys_fault_i,
  // Point outputs
  output logic [ops_pkg::NPTS-1:0] point_active_o,
  output logic [ops_pkg::PIDX_W-1:0] applied_point_o,
  output logic override_en_o,
  // Status flags
  output logic mult_err_o,
  output logic nomatch_err_o,
  output logic entry_err_o,
  output logic sys_err_o
);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Configuration and table storage
  logic [ops_pkg::CTRL_W-1:0] ctrl;
  logic [ops_pkg::PIDX_W-1:0] manual_point_override;
  logic [ops_pkg::PIDX_W-1:0] point_count;
  logic [ops_pkg::PIDX_W-1:0] error_point_index;
  logic [ops_pkg::LOOP_W-1:0] loop_limit;
  logic [ops_pkg::PIDX_W-1:0] tbl_idx;
  logic [31:0] dwell_mem [ops_pkg::NPTS];
  logic [31:0] lo_mem [ops_pkg::NPTS];
  logic [31:0] hi_mem [ops_pkg::NPTS];

  // Sequencer state
  logic [ops_pkg::PIDX_W-1:0] active;
  logic [ops_pkg::PIDX_W-1:0] next_active;
  logic [ops_pkg::DWELL_W-1:0] elapsed;
  logic [ops_pkg::LOOP_W-1:0] loops_done_count;
  ops_pkg::ops_seq_t seq_state;
  logic [ops_pkg::MSDIV_W-1:0] ms_div;
  logic ms_tick;
  logic fault_meta;
  logic fault_sync;

  // Scanner state and latched results
  logic [ops_pkg::PIDX_W-1:0] scan_idx;
  logic [1:0] acc_cnt;
  logic [ops_pkg::PIDX_W-1:0] acc_hi;
  logic acc_bad_rng;
  logic acc_bad_dwell;
  logic scan_done;
  logic [1:0] res_cnt;
  logic [ops_pkg::PIDX_W-1:0] res_hi;
  logic res_bad_rng;
  logic res_bad_dwell;

  // Control decode
  logic en, pause, rewind, manual, trig, hold, multerr, ignsys;
  assign en = ctrl[ops_pkg::CTRL_EN];
  assign pause = ctrl[ops_pkg::CTRL_PAUSE];
  assign rewind = ctrl[ops_pkg::CTRL_REWIND];
  assign manual = ctrl[ops_pkg::CTRL_MANUAL];
  assign trig = ctrl[ops_pkg::CTRL_TRIG];
  assign hold = ctrl[ops_pkg::CTRL_HOLD];
  assign multerr = ctrl[ops_pkg::CTRL_MULTERR];
  assign ignsys = ctrl[ops_pkg::CTRL_IGNSYS];

  // Loop limit after byte-lane merge; only the low half is kept
  logic [31:0] loop_merged;
  assign loop_merged = merge({16'h0000, loop_limit}, avs_writedata_i,
                             avs_byteenable_i);

  // Bus access is taken on the edge where waitrequest is already low
  logic acc_wr, acc_rd;
  assign acc_wr = avs_write_i && !avs_waitrequest_o;
  assign acc_rd = avs_read_i && !avs_waitrequest_o;

  // One wait state per access, then waitrequest rises again
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Configuration register writes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl <= ops_pkg::CTRL_RST;
      manual_point_override <= ops_pkg::PIDX_RST;
      point_count <= ops_pkg::PIDX_RST;
      error_point_index <= ops_pkg::PIDX_RST;
      loop_limit <= ops_pkg::LOOP_RST;
      tbl_idx <= ops_pkg::PIDX_RST;
    end else if (acc_wr) begin
      unique case (avs_address_i)
        ops_pkg::OFS_CTRL: begin
          ctrl <= avs_byteenable_i[0] ? avs_writedata_i[7:0] : ctrl;
        end
        ops_pkg::OFS_MANUAL: begin
          manual_point_override <= avs_byteenable_i[0] ?
            avs_writedata_i[7:0] : manual_point_override;
        end
        ops_pkg::OFS_COUNT: begin
          // Clamp keeps the scan inside the table
          if (avs_byteenable_i[0]) begin
            point_count <= (avs_writedata_i[7:0] > 8'(ops_pkg::NPTS)) ?
              8'(ops_pkg::NPTS) : avs_writedata_i[7:0];
          end
        end
        ops_pkg::OFS_ERRPT: begin
          error_point_index <= avs_byteenable_i[0] ?
            avs_writedata_i[7:0] : error_point_index;
        end
        ops_pkg::OFS_LOOPLIM: begin
          loop_limit <= loop_merged[ops_pkg::LOOP_W-1:0];
        end
        ops_pkg::OFS_TIDX: begin
          tbl_idx <= avs_byteenable_i[0] ? avs_writedata_i[7:0] : tbl_idx;
        end
        default: begin
        end
      endcase
    end
  end

  // Table writes; an index outside the table drops the write
  always_ff @(posedge clk_i) begin
    if (acc_wr && tbl_idx < 8'(ops_pkg::NPTS)) begin
      unique case (avs_address_i)
        ops_pkg::OFS_TDWELL: begin
          dwell_mem[tbl_idx] <= merge(dwell_mem[tbl_idx], avs_writedata_i,
                                      avs_byteenable_i);
        end
        ops_pkg::OFS_TLO: begin
          lo_mem[tbl_idx] <= merge(lo_mem[tbl_idx], avs_writedata_i,
                                   avs_byteenable_i);
        end
        ops_pkg::OFS_THI: begin
          hi_mem[tbl_idx] <= merge(hi_mem[tbl_idx], avs_writedata_i,
                                   avs_byteenable_i);
        end
        default: begin
        end
      endcase
    end
  end

  // Read data, captured as waitrequest drops; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= 32'h0000_0000;
      unique case (avs_address_i)
        ops_pkg::OFS_CTRL: avs_readdata_o[7:0] <= ctrl;
        ops_pkg::OFS_MANUAL: avs_readdata_o[7:0] <= manual_point_override;
        ops_pkg::OFS_COUNT: avs_readdata_o[7:0] <= point_count;
        ops_pkg::OFS_ERRPT: avs_readdata_o[7:0] <= error_point_index;
        ops_pkg::OFS_LOOPLIM: avs_readdata_o[15:0] <= loop_limit;
        ops_pkg::OFS_STATUS: begin
          avs_readdata_o[7:0] <= active;
          avs_readdata_o[ops_pkg::ST_MULT] <= mult_err_o;
          avs_readdata_o[ops_pkg::ST_NOMATCH] <= nomatch_err_o;
          avs_readdata_o[ops_pkg::ST_ENTRY] <= entry_err_o;
          avs_readdata_o[ops_pkg::ST_SYS] <= sys_err_o;
          avs_readdata_o[ops_pkg::ST_DONE] <= (seq_state == ops_pkg::SQ_DONE);
        end
        ops_pkg::OFS_LOOPDONE: begin
          avs_readdata_o[15:0] <= loops_done_count;
        end
        ops_pkg::OFS_ELAPSED: begin
          avs_readdata_o[30:0] <= elapsed;
        end
        ops_pkg::OFS_COND: begin
          // Active condition is the point chosen by the last scan
          avs_readdata_o[7:0] <= res_hi;
          avs_readdata_o[ops_pkg::COND_VALID] <= (res_cnt != 2'd0);
        end
        ops_pkg::OFS_TIDX: avs_readdata_o[7:0] <= tbl_idx;
        ops_pkg::OFS_TDWELL: begin
          avs_readdata_o <= (tbl_idx < 8'(ops_pkg::NPTS)) ?
            dwell_mem[tbl_idx] : 32'h0000_0000;
        end
        ops_pkg::OFS_TLO: begin
          avs_readdata_o <= (tbl_idx < 8'(ops_pkg::NPTS)) ?
            lo_mem[tbl_idx] : 32'h0000_0000;
        end
        ops_pkg::OFS_THI: begin
          avs_readdata_o <= (tbl_idx < 8'(ops_pkg::NPTS)) ?
            hi_mem[tbl_idx] : 32'h0000_0000;
        end
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Fault pin synchroniser
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end else begin
      fault_meta <= sys_fault_i;
      fault_sync <= fault_meta;
    end
  end

  // Last divider count before the millisecond pulse
  localparam logic [ops_pkg::MSDIV_W-1:0] MSDIV_LAST =
    ops_pkg::MSDIV_W'(MS_CYCLES - 1);

  // Millisecond enable pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
    end else if (ms_div >= MSDIV_LAST) begin
      ms_div <= '0;
      ms_tick <= 1'b1;
    end else begin
      ms_div <= ms_div + 1'b1;
      ms_tick <= 1'b0;
    end
  end

  // Range test of the point under scan against its own variable
  logic [31:0] lo_w, hi_w, dw_w;
  logic [ops_pkg::PVSEL_W-1:0] pv_sel;
  logic [ops_pkg::PV_W-1:0] pv;
  logic lo_ok, hi_ok, hit, in_scan;
  assign in_scan = scan_idx < point_count;
  assign lo_w = lo_mem[in_scan ? scan_idx : 8'h00];
  assign hi_w = hi_mem[in_scan ? scan_idx : 8'h00];
  assign dw_w = dwell_mem[in_scan ? scan_idx : 8'h00];
  assign pv_sel = lo_w[ops_pkg::LO_PVSEL +: ops_pkg::PVSEL_W];
  assign pv = pv_i[pv_sel*ops_pkg::PV_W +: ops_pkg::PV_W];
  assign lo_ok = lo_w[ops_pkg::LO_INCL] ? (pv >= lo_w[15:0]) :
                 (pv > lo_w[15:0]);
  assign hi_ok = hi_w[ops_pkg::HI_INCL] ? (pv <= hi_w[15:0]) :
                 (pv < hi_w[15:0]);
  assign hit = lo_w[ops_pkg::LO_BLANK] || (lo_ok && hi_ok);

  // Scanner visits one point per clock; a pass costs point_count + 1
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scan_idx <= '0;
      acc_cnt <= 2'd0;
      acc_hi <= '0;
      acc_bad_rng <= 1'b0;
      acc_bad_dwell <= 1'b0;
      scan_done <= 1'b0;
      res_cnt <= 2'd0;
      res_hi <= '0;
      res_bad_rng <= 1'b0;
      res_bad_dwell <= 1'b0;
    end else if (in_scan) begin
      scan_idx <= scan_idx + 1'b1;
      scan_done <= 1'b0;
      // Ascending scan, so the last hit is the highest index
      if (hit && !lo_w[ops_pkg::LO_BAD]) begin
        acc_cnt <= (acc_cnt == 2'd2) ? 2'd2 : acc_cnt + 1'b1;
        acc_hi <= scan_idx;
      end
      acc_bad_rng <= acc_bad_rng || lo_w[ops_pkg::LO_BAD];
      acc_bad_dwell <= acc_bad_dwell || dw_w[ops_pkg::DWELL_BAD];
    end else begin
      scan_idx <= '0;
      scan_done <= 1'b1;
      res_cnt <= acc_cnt;
      res_hi <= acc_hi;
      res_bad_rng <= acc_bad_rng;
      res_bad_dwell <= acc_bad_dwell;
      acc_cnt <= 2'd0;
      acc_hi <= '0;
      acc_bad_rng <= 1'b0;
      acc_bad_dwell <= 1'b0;
    end
  end

  // Timed step conditions
  logic sys_stop, run_tick, expired, last_pt, more_loops;
  assign sys_stop = fault_sync && !ignsys;
  assign run_tick = en && !trig && !manual && !sys_stop && !rewind &&
                    !pause && !res_bad_dwell && ms_tick &&
                    seq_state == ops_pkg::SQ_RUN;
  assign expired = (elapsed + 1'b1) >= dwell_mem[active][30:0];
  assign last_pt = (active + 1'b1) >= point_count;
  assign more_loops = (loop_limit == '0) ||
                      ((loops_done_count + 1'b1) < loop_limit);

  // Next active point, in falling priority
  always_comb begin
    next_active = active;
    if (!en) begin
      next_active = active;
    end else if (manual) begin
      next_active = manual_point_override;
    end else if (sys_stop) begin
      next_active = error_point_index;
    end else if (trig) begin
      // Takes the evaluated point again after manual release
      if (scan_done) begin
        if (res_bad_rng) begin
          next_active = error_point_index;
        end else if (res_cnt == 2'd0) begin
          next_active = hold ? active : error_point_index;
        end else if (res_cnt == 2'd2 && multerr) begin
          next_active = error_point_index;
        end else begin
          next_active = res_hi;
        end
      end
    end else if (rewind) begin
      next_active = '0;
    end else if (res_bad_dwell) begin
      next_active = error_point_index;
    end else if (run_tick && expired) begin
      // Continues from whatever point is active, manual or not
      if (!last_pt) begin
        next_active = active + 1'b1;
      end else if (more_loops) begin
        next_active = '0;
      end
    end
  end

  // Active point and its one-hot indicators
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      active <= '0;
      point_active_o <= '0;
      point_active_o[0] <= 1'b1;
    end else begin
      active <= next_active;
      point_active_o <= '0;
      if (next_active < 8'(ops_pkg::NPTS)) begin
        point_active_o[next_active] <= 1'b1;
      end
    end
  end

  // Dwell timer restarts on every point change
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      elapsed <= '0;
    end else if (next_active != active || (en && !trig && rewind)) begin
      elapsed <= '0;
    end else if (run_tick) begin
      elapsed <= elapsed + 1'b1;
    end
  end

  // Loop counting and end of sequence
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      loops_done_count <= ops_pkg::LOOP_RST;
      seq_state <= ops_pkg::SQ_RUN;
    end else if (en && !trig && rewind) begin
      loops_done_count <= ops_pkg::LOOP_RST;
      seq_state <= ops_pkg::SQ_RUN;
    end else if (run_tick && expired && last_pt && !res_bad_dwell) begin
      loops_done_count <= loops_done_count + 1'b1;
      seq_state <= more_loops ? ops_pkg::SQ_RUN : ops_pkg::SQ_DONE;
    end
  end

  // Override output freezes at the last applied point when disabled
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      applied_point_o <= '0;
      override_en_o <= 1'b0;
    end else begin
      override_en_o <= en;
      if (en) begin
        applied_point_o <= next_active;
      end
    end
  end

  // Status flags; match and entry flags refreshed at the end of each scan, system flag every clock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mult_err_o <= 1'b0;
      nomatch_err_o <= 1'b0;
      entry_err_o <= 1'b0;
      sys_err_o <= 1'b0;
    end else begin
      sys_err_o <= fault_sync;
      if (scan_done) begin
        mult_err_o <= trig && multerr && res_cnt == 2'd2;
        nomatch_err_o <= trig && res_cnt == 2'd0;
        entry_err_o <= trig ? res_bad_rng : res_bad_dwell;
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/ops_sequencer_monitor.sv ***
// Port-level assertions for the operating point sequencer
`default_nettype none
module ops_sequencer_monitor (
  // Clock, reset and register bus
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Fault pin, point outputs and flags
  input wire logic sys_fault_i,
  input wire logic [ops_pkg::NPTS-1:0] point_active_o,
  input wire logic [ops_pkg::PIDX_W-1:0] applied_point_o,
  input wire logic override_en_o,
  input wire logic mult_err_o,
  input wire logic nomatch_err_o,
  input wire logic sys_err_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Bus steps: request taken, then exactly one low cycle of wait
  sequence req_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence one_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  // Pin held past the two-flop synchroniser and output register
  sequence fault_held;
    sys_fault_i [*5];
  endsequence
  sequence fault_gone;
    !sys_fault_i [*5];
  endsequence
  bus_ack_a: assert property (req_taken |=> one_ack)
    else $error("bus answer not after one wait");
  ack_cause_a: assert property
    (!avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("bus answer without request");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i > 8'h30 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property
    (avs_write_i && !avs_waitrequest_o |=> $stable(avs_readdata_o))
    else $error("read data moved on write");
  one_hot_a: assert property ($onehot0(point_active_o))
    else $error("several points active");
  frozen_point_a: assert property (!override_en_o &&
    !$past(override_en_o) |-> $stable(applied_point_o))
    else $error("point moved while disabled");
  match_flags_a: assert property (!(mult_err_o && nomatch_err_o))
    else $error("both match flags set");
  sys_set_a: assert property (fault_held |-> sys_err_o)
    else $error("system flag missing");
  sys_clear_a: assert property (fault_gone |-> !sys_err_o)
    else $error("system flag stuck");
endmodule
`default_nettype wire

// *** tb/ops_sequencer_tb.sv ***
// Self-checking bench for the operating point sequencer
`default_nettype none
module ops_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 4;
  localparam int EP = 3;
  // Design signals
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [ops_pkg::NPV*ops_pkg::PV_W-1:0] pv_i = '0;
  logic sys_fault_i = 1'b0;
  logic [ops_pkg::NPTS-1:0] point_active_o;
  logic [7:0] applied_point_o;
  logic override_en_o, mult_err_o, nomatch_err_o, entry_err_o, sys_err_o;
  // Bench state
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'hee72;
  int cyc_n = 0;
  int pq[$];
  int tq[$];
  int dw[3] = '{2, 5, 2};
  int lb[3] = '{0, 50, 100};
  int hb[3] = '{99, 149, 199};
  int xp, n0, e1, p;
  logic [7:0] prev_pt = 8'h00;
  logic [31:0] rd;
  logic [7:0] c;
  logic f;
  logic [127:0] pvr;

  ops_sequencer #(.MS_CYCLES(MSC)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pv_i(pv_i), .sys_fault_i(sys_fault_i), .point_active_o(point_active_o),
    .applied_point_o(applied_point_o), .override_en_o(override_en_o),
    .mult_err_o(mult_err_o), .nomatch_err_o(nomatch_err_o),
    .entry_err_o(entry_err_o), .sys_err_o(sys_err_o)
  );

  always #20 clk_i = ~clk_i;

  // Log each change of the applied point with its cycle number
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    prev_pt <= applied_point_o;
    if (!srst_i && applied_point_o !== prev_pt) begin
      pq.push_back(applied_point_o);
      tq.push_back(cyc_n);
    end
  end

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One bus cycle; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    // No local limit: only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Table row: dwell, low word, inclusive high bound
  task automatic row(input int i, input int d, input logic [31:0] lo,
                     input logic [15:0] hi);
    bus(1, ops_pkg::OFS_TIDX, 32'(i));
    bus(1, ops_pkg::OFS_TDWELL, 32'(d));
    bus(1, ops_pkg::OFS_TLO, lo);
    bus(1, ops_pkg::OFS_THI, {15'h0, 1'b1, hi});
  endtask

  // Apply control and fault, let scans settle, compare with model
  task automatic trig(input logic [7:0] cv, input logic fv);
    int m, top;
    m = 0;
    top = 0;
    bus(1, ops_pkg::OFS_CTRL, {24'h0, cv});
    sys_fault_i <= fv;
    cy(24);
    for (int i = 0; i < 3; i++) begin
      if (pv_i[16*(i+1) +: 16] >= lb[i] && pv_i[16*(i+1) +: 16] <= hb[i]) begin
        m++;
        top = i;
      end
    end
    if (fv && !cv[7]) xp = EP;
    else if (m == 0) xp = cv[5] ? xp : EP;
    else if (m > 1 && cv[6]) xp = EP;
    else xp = top;
    ck(applied_point_o, xp);
    ck(point_active_o[xp], 1'b1);
    ck(nomatch_err_o, m == 0);
    ck(mult_err_o, m > 1 && cv[6]);
    ck(sys_err_o, fv);
    bus(0, ops_pkg::OFS_COND, 0);
    ck(rd[8:0], m ? {1'b1, 8'(top)} : 9'h000);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: tests need just under two thousand cycles
  initial begin
    cy(20000);
    n_fail++;
    wrap_up();
  end

  initial begin
    cy(16);
    srst_i <= 1'b0;
    cy(1);
    ck(point_active_o[0], 1'b1);
    bus(0, ops_pkg::OFS_CTRL, 0);
    ck(rd, 32'(ops_pkg::CTRL_RST));
    bus(0, 8'h40, 0);
    ck(rd, 0);
    bus(1, ops_pkg::OFS_COUNT, 255);
    bus(0, ops_pkg::OFS_COUNT, 0);
    ck(rd, 32'(ops_pkg::NPTS));
    bus(1, ops_pkg::OFS_COUNT, 3);
    bus(1, ops_pkg::OFS_ERRPT, EP);
    bus(1, ops_pkg::OFS_LOOPLIM, 2);
    row(0, 2, 32'h0011_0000, 16'd99);
    row(1, 5, 32'h0021_0032, 16'd149);
    row(2, 2, 32'h0031_0064, 16'd199);
    row(3, 2, 32'h0003_0000, 16'd0);
    n0 = pq.size();
    bus(1, ops_pkg::OFS_CTRL, 1);
    // Enable copy is registered one edge after the control write
    cy(1);
    ck(override_en_o, 1'b1);
    cy(120);
    ck(pq.size() - n0, 5);
    for (int k = 0; k < 5; k++) begin
      ck(pq[n0+k], (k + 1) % 3);
      p = k ? tq[n0+k] - tq[n0+k-1] - MSC * dw[pq[n0+k-1]] : 0;
      ck(p >= -4 && p <= 4, 1'b1);
    end
    bus(0, ops_pkg::OFS_LOOPDONE, 0);
    ck(rd, 2);
    bus(0, ops_pkg::OFS_STATUS, 0);
    ck(rd[ops_pkg::ST_DONE], 1'b1);
    $display("test timed loops done");
    bus(1, ops_pkg::OFS_LOOPLIM, 0);
    bus(1, ops_pkg::OFS_CTRL, 5);
    cy(4);
    ck(applied_point_o, 0);
    bus(1, ops_pkg::OFS_CTRL, 1);
    cy(10);
    bus(1, ops_pkg::OFS_CTRL, 3);
    cy(4);
    p = applied_point_o;
    bus(0, ops_pkg::OFS_ELAPSED, 0);
    e1 = rd;
    ck(e1 <= dw[p], 1'b1);
    cy(20);
    bus(0, ops_pkg::OFS_ELAPSED, 0);
    ck(rd, e1);
    ck(applied_point_o, p);
    bus(1, ops_pkg::OFS_MANUAL, 2);
    bus(1, ops_pkg::OFS_CTRL, 9);
    cy(4);
    ck(applied_point_o, 2);
    n0 = pq.size();
    bus(1, ops_pkg::OFS_CTRL, 1);
    ck(applied_point_o, 2);
    cy(60);
    ck(pq.size() > n0 + 3, 1'b1);
    bus(1, ops_pkg::OFS_TIDX, 1);
    bus(1, ops_pkg::OFS_TDWELL, 32'h8000_0005);
    cy(8);
    ck({entry_err_o, applied_point_o}, {1'b1, 8'(EP)});
    bus(1, ops_pkg::OFS_TDWELL, 5);
    $display("test timed controls done");
    // Known single match before each new setting avoids hold ambiguity
    repeat (24) begin
      c = 8'h11 | (8'($random(seed)) & 8'he0);
      f = ($random(seed) & 3) == 0;
      pv_i <= 128'h000a_0000;
      trig(c, f);
      for (int k = 0; k < 8; k++) begin
        pvr[16*k +: 16] = 16'($random(seed)) & 16'h00ff;
      end
      pv_i <= pvr;
      trig(c, f);
    end
    bus(1, ops_pkg::OFS_MANUAL, 1);
    bus(1, ops_pkg::OFS_CTRL, 8'h19);
    cy(8);
    ck(applied_point_o, 1);
    pv_i <= 128'h0096_00c8_00c8_0000;
    trig(8'h11, 1'b0);
    bus(1, ops_pkg::OFS_CTRL, 0);
    pv_i <= 128'h000a_0000;
    cy(24);
    ck({override_en_o, applied_point_o}, 9'h002);
    bus(1, ops_pkg::OFS_TLO, 32'h0025_0032);
    bus(1, ops_pkg::OFS_CTRL, 8'h11);
    cy(24);
    ck({entry_err_o, applied_point_o}, {1'b1, 8'(EP)});
    $display("test trigger done");
    wrap_up();
  end
endmodule

bind ops_sequencer ops_sequencer_monitor u_mon (
  .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sys_fault_i(sys_fault_i), .point_active_o(point_active_o),
  .applied_point_o(applied_point_o), .override_en_o(override_en_o),
  .mult_err_o(mult_err_o), .nomatch_err_o(nomatch_err_o),
  .sys_err_o(sys_err_o)
);
`default_nettype wire
